// ### inc/ext_bus_pkg.sv
package ext_bus_pkg;
   // Address bus width
   localparam int ADDR_W = 32;
   // Data bus width
   localparam int DATA_W = 64;
   // Half of the data bus
   localparam int WORD_W = 32;
   // Upper address field for bank decode
   localparam int BANK_HI = 31;
   localparam int BANK_LO = 26;
   localparam logic [5:0] BANK0_CODE = 6'h02;
   localparam logic [5:0] BANK1_CODE = 6'h03;
   // Upper address field for host space decode
   localparam int HOST_HI = 31;
   localparam int HOST_LO = 28;
   localparam logic [3:0] HOST_LOCAL_CODE = 4'h0;
   // Reset values of control state
   localparam logic BOOT_RESET = 1'b0;
   localparam logic STROBE_IDLE_N = 1'b1;
   // Ack samples still in the synchroniser when an access starts
   localparam logic [1:0] ACK_SETTLE = 2'h2;

   // Master request from the core side
   typedef struct packed {
      logic [31:0] addr;
      logic [63:0] wdata;
      logic write;
      logic long_word;
      logic zone32;
      logic sdram;
   } master_req_t;

   // Slave access seen on the pins
   typedef struct packed {
      logic [31:0] addr;
      logic read;
      logic write_low;
      logic write_high;
   } slave_req_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_MASTER,
      ST_SLAVE_RD
   } bus_state_t;
endpackage

// ### core/sync_cell.sv
`timescale 1ns/100ps
module sync_cell #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_dout;

   // Two flops; the first is only read by the second
   always_comb
   begin
      next_stage1 = din;
      next_dout = stage1;
   end

   // No reset: straps must be readable while reset is held
   always_ff @(posedge mclk)
   begin
      stage1 <= next_stage1;
      dout <= next_dout;
   end
endmodule // sync_cell

// ### core/external_bus_control_port.sv
`timescale 1ns/100ps
module external_bus_control_port
   import ext_bus_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic bus_clock_freq_select,
   input wire logic bus_grant,
   input wire logic boot_active,
   input wire ext_bus_pkg::master_req_t m_req,
   input wire logic m_valid,
   output logic m_ready,
   output logic m_done,
   output logic [63:0] m_rdata,
   output ext_bus_pkg::slave_req_t s_req,
   output logic s_valid,
   input wire logic [63:0] s_rdata,
   input wire logic s_rdata_ready,
   output logic [63:0] s_wdata,
   output logic boot_external,
   input wire logic [31:0] address_bus_in,
   output logic [31:0] address_bus_out,
   output logic address_bus_oe,
   input wire logic [63:0] data_bus_in,
   output logic [63:0] data_bus_out,
   output logic data_bus_oe,
   input wire logic read_strobe_n_in,
   output logic read_strobe_n_out,
   input wire logic write_low_strobe_n_in,
   output logic write_low_strobe_n_out,
   input wire logic write_high_strobe_n_in,
   output logic write_high_strobe_n_out,
   output logic strobe_oe,
   input wire logic ack_in,
   output logic ack_out,
   output logic ack_oe,
   input wire logic external_boot_strap,
   output logic boot_memory_select_n,
   output logic [1:0] bank_select_n,
   output logic host_space_select_n,
   output logic select_oe
);
   import ext_bus_pkg::*;

   // Bank 0 (index 0) or bank 1 (index 1) hit
   function automatic logic [1:0] bank_decode(input logic [31:0] a);
      logic [1:0] hit;
      hit = 2'h0;
      hit[0] = (a[BANK_HI:BANK_LO] == BANK0_CODE);
      hit[1] = (a[BANK_HI:BANK_LO] == BANK1_CODE);
      return hit;
   endfunction

   ////////////////////////////////////////////////////////////////
   // Input synchronisers
   logic [2:0] strobe_sync;
   logic ack_sync;
   logic [1:0] misc_sync;

   sync_cell #(.WIDTH(3)) u_strobe_sync (
      .mclk(mclk),
      .din({read_strobe_n_in, write_low_strobe_n_in, write_high_strobe_n_in}),
      .dout(strobe_sync)
   );

   sync_cell #(.WIDTH(1)) u_ack_sync (
      .mclk(mclk),
      .din(ack_in),
      .dout(ack_sync)
   );

   sync_cell #(.WIDTH(2)) u_misc_sync (
      .mclk(mclk),
      .din({external_boot_strap, bus_clock_freq_select}),
      .dout(misc_sync)
   );

   ////////////////////////////////////////////////////////////////
   // Bus state machine
   bus_state_t state;
   bus_state_t next_state;
   logic [31:0] addr_q;
   logic [31:0] next_addr_q;
   logic [63:0] wdata_q;
   logic [63:0] next_wdata_q;
   logic rd_n_q, wrl_n_q, wrh_n_q;
   logic next_rd_n_q, next_wrl_n_q, next_wrh_n_q;
   logic [63:0] next_m_rdata;
   logic next_m_done;
   logic [63:0] s_rdata_q;
   logic [63:0] next_s_rdata_q;
   logic s_drive, rd_served;
   logic next_s_drive, next_rd_served;
   logic in_reset_q;
   logic [1:0] settle, next_settle;
   logic boot_q;
   logic next_boot_q;
   logic rd_s, wrl_s, wrh_s;

   assign rd_s = ~strobe_sync[2];
   assign wrl_s = ~strobe_sync[1];
   assign wrh_s = ~strobe_sync[0];

   // Ready only while idle and holding the bus
   assign m_ready = (state == ST_IDLE) && bus_grant && !in_reset_q;

   always_comb
   begin
      next_state = state;
      next_addr_q = addr_q;
      next_wdata_q = wdata_q;
      next_rd_n_q = rd_n_q;
      next_wrl_n_q = wrl_n_q;
      next_wrh_n_q = wrh_n_q;
      next_m_rdata = m_rdata;
      next_m_done = 1'b0;
      next_s_rdata_q = s_rdata_q;
      next_s_drive = 1'b0;
      // Stale ack samples from before the access are skipped
      next_settle = (state == ST_MASTER) ? settle + {1'b0, settle != ACK_SETTLE} : 2'h0;
      // A served read stays served until its strobe is released
      next_rd_served = (rd_served || (state == ST_SLAVE_RD && s_drive)) && rd_s;
      unique case (state)
         ST_IDLE:
         begin
            if (m_valid && m_ready)
            begin
               next_state = ST_MASTER;
               next_addr_q = m_req.addr;
               next_wdata_q = m_req.wdata;
               next_rd_n_q = m_req.write || m_req.sdram;
               next_wrl_n_q = !(m_req.write && (m_req.zone32 || m_req.long_word || !m_req.addr[0]));
               next_wrh_n_q = !(m_req.write && !m_req.zone32 && (m_req.long_word || m_req.addr[0]));
            end
            else if (!bus_grant && rd_s && !rd_served)
            begin
               next_state = ST_SLAVE_RD;
            end
         end
         ST_MASTER:
         begin
            if (ack_sync && (settle == ACK_SETTLE))
            begin
               next_state = ST_IDLE;
               next_m_done = 1'b1;
               next_m_rdata = data_bus_in;
               next_rd_n_q = STROBE_IDLE_N;
               next_wrl_n_q = STROBE_IDLE_N;
               next_wrh_n_q = STROBE_IDLE_N;
            end
         end
         ST_SLAVE_RD:
         begin
            if (s_rdata_ready && !s_drive)
            begin
               next_s_rdata_q = s_rdata;
               next_s_drive = 1'b1;
            end
            if (s_drive || !rd_s)
            begin
               next_state = ST_IDLE;
            end
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         addr_q <= '0;
         wdata_q <= '0;
         rd_n_q <= STROBE_IDLE_N;
         wrl_n_q <= STROBE_IDLE_N;
         wrh_n_q <= STROBE_IDLE_N;
         m_rdata <= '0;
         m_done <= 1'b0;
         s_rdata_q <= '0;
         s_drive <= 1'b0;
         rd_served <= 1'b0;
         settle <= 2'h0;
         in_reset_q <= 1'b1;
      end
      else
      begin
         state <= next_state;
         addr_q <= next_addr_q;
         wdata_q <= next_wdata_q;
         rd_n_q <= next_rd_n_q;
         wrl_n_q <= next_wrl_n_q;
         wrh_n_q <= next_wrh_n_q;
         m_rdata <= next_m_rdata;
         m_done <= next_m_done;
         s_rdata_q <= next_s_rdata_q;
         s_drive <= next_s_drive;
         rd_served <= next_rd_served;
         settle <= next_settle;
         in_reset_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Boot strap, caught while reset is held
   always_comb
   begin
      next_boot_q = rst ? ~misc_sync[1] : boot_q;
   end

   always_ff @(posedge mclk)
   begin
      boot_q <= next_boot_q;
   end

   assign boot_external = boot_q;

   ////////////////////////////////////////////////////////////////
   // Pin drive; everything released during reset
   logic master_drive;
   logic [1:0] bank_hit;

   assign master_drive = bus_grant && !rst && !in_reset_q;
   assign bank_hit = bank_decode(addr_q);

   assign address_bus_out = addr_q;
   assign address_bus_oe = master_drive;
   // data driven on writes, on sdram accesses or on slave read
   assign data_bus_out = s_drive ? s_rdata_q : wdata_q;
   assign data_bus_oe = !rst && ((master_drive && (state == ST_MASTER) && rd_n_q) || s_drive);
   assign read_strobe_n_out = rd_n_q;
   assign write_low_strobe_n_out = wrl_n_q;
   assign write_high_strobe_n_out = wrh_n_q;
   assign strobe_oe = master_drive;
   assign select_oe = master_drive;
   assign bank_select_n = ~(bank_hit & {2{state == ST_MASTER}});
   assign host_space_select_n = ~((addr_q[HOST_HI:HOST_LO] != HOST_LOCAL_CODE) && (state == ST_MASTER));
   assign boot_memory_select_n = ~(boot_q && boot_active && (state == ST_MASTER));
   assign ack_out = s_drive;
   assign ack_oe = !rst && (state == ST_SLAVE_RD);

   ////////////////////////////////////////////////////////////////
   // slave write strobes per half word
   assign s_req.addr = address_bus_in;
   assign s_req.read = rd_s;
   assign s_req.write_low = wrl_s;
   assign s_req.write_high = wrh_s;
   assign s_valid = !bus_grant && !in_reset_q && (rd_s || wrl_s || wrh_s) && (state != ST_SLAVE_RD) && !rd_served;
   assign s_wdata = data_bus_in;
endmodule // external_bus_control_port

// ### verification/bus_port_checker_asserts.sv
`timescale 1ns/100ps
module bus_port_checker
   import ext_bus_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire ext_bus_pkg::master_req_t m_req,
   input wire logic m_valid,
   input wire logic m_ready,
   input wire ext_bus_pkg::slave_req_t s_req,
   input wire logic s_rdata_ready,
   input wire logic [31:0] address_bus_out,
   input wire logic read_strobe_n_out,
   input wire logic write_low_strobe_n_out,
   input wire logic write_high_strobe_n_out,
   input wire logic strobe_oe,
   input wire logic ack_out,
   input wire logic ack_oe,
   input wire logic [1:0] bank_select_n,
   input wire logic host_space_select_n,
   input wire logic select_oe,
   input wire logic boot_active,
   input wire logic boot_external,
   input wire logic boot_memory_select_n
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic take, wr, wl_exp, wh_exp, busy;
   // Master access in flight: some strobe asserted
   assign busy = strobe_oe && !(read_strobe_n_out && write_low_strobe_n_out && write_high_strobe_n_out);
   // Accepted request and the strobes it should raise
   assign take = m_valid && m_ready;
   assign wr = take && m_req.write;
   assign wl_exp = !m_req.addr[0] || m_req.zone32 || m_req.long_word;
   assign wh_exp = !m_req.zone32 && (m_req.addr[0] || m_req.long_word);
   ////////////////////////////////////////
   read_strobe_a: assert property (take && !m_req.write && !m_req.sdram |=>
      strobe_oe && !read_strobe_n_out && address_bus_out == $past(m_req.addr))
      else $error("read strobe or address late");
   write_low_a: assert property (wr |=> write_low_strobe_n_out == !$past(wl_exp))
      else $error("low write strobe wrong");
   write_high_a: assert property (wr |=> write_high_strobe_n_out == !$past(wh_exp))
      else $error("high write strobe wrong");
   bank_one_a: assert property (busy && address_bus_out[31:26] == BANK1_CODE |->
      bank_select_n == 2'h1)
      else $error("bank one select wrong");
   bank_zero_a: assert property (busy && address_bus_out[31:26] == BANK0_CODE |->
      bank_select_n == 2'h2)
      else $error("bank zero select wrong");
   host_space_a: assert property (busy |->
      host_space_select_n == (address_bus_out[31:28] == HOST_LOCAL_CODE))
      else $error("host space select wrong");
   boot_select_a: assert property (busy |-> boot_memory_select_n == !(boot_active && boot_external))
      else $error("boot select wrong");
   write_no_ack_a: assert property (s_req.write_low || s_req.write_high |-> !ack_oe)
      else $error("ack driven in slave write");
   read_stretch_a: assert property (ack_oe && !ack_out |=>
      ack_oe && ack_out == $past(s_rdata_ready))
      else $error("slave read stretch wrong");
   cover property (wr);
   cover property (take && !m_req.write);
   cover property (ack_oe && ack_out);
endmodule // bus_port_checker

bind external_bus_control_port bus_port_checker u_checker (.*);

// ### verification/ext_mem_model.sv
`timescale 1ns/100ps
module ext_mem_model (
   input wire logic mclk,
   input wire logic strobe_oe,
   input wire logic [31:0] address_bus_out,
   input wire logic read_strobe_n_out,
   input wire logic write_low_strobe_n_out,
   input wire logic write_high_strobe_n_out,
   input wire logic [63:0] data_bus_out,
   input wire logic [3:0] waits,
   output logic mem_ack,
   output logic [63:0] mem_data,
   output logic [1:0] seen_wr,
   output logic [63:0] seen_data
);
   logic [3:0] cnt = 4'h0;
   logic [63:0] drift = 64'h0;
   logic rd, on;
   // Slave selected by any master strobe
   assign rd = strobe_oe && !read_strobe_n_out;
   assign on = rd || (strobe_oe && !(write_low_strobe_n_out && write_high_strobe_n_out));
   ////////////////////////////////////////
   // wait states
   assign mem_ack = !on || cnt >= waits;
   // Released lines drift, never hold
   assign mem_data = rd && mem_ack ? {~address_bus_out, address_bus_out} : drift;
   // Count waits, capture writes
   always @(posedge mclk)
   begin
      drift <= ~mem_data;
      cnt <= on && !mem_ack ? cnt + 4'h1 : on ? cnt : 4'h0;
      if (on && mem_ack && !rd)
      begin
         seen_wr <= {~write_high_strobe_n_out, ~write_low_strobe_n_out};
         seen_data <= data_bus_out;
      end
   end
endmodule // ext_mem_model

// ### verification/external_bus_control_port_test.sv
`timescale 1ns/100ps
module external_bus_control_port_test;
   import ext_bus_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic bus_clock_freq_select = 1'b1;
   logic bus_grant = 1'b1, boot_active = 1'b1, m_valid = 1'b0, s_rdata_ready = 1'b0;
   logic external_boot_strap = 1'b0, trd = 1'b1, twl = 1'b1, twh = 1'b1;
   master_req_t m_req = '0;
   logic [63:0] s_rdata = 64'h0, td = 64'h0;
   logic [31:0] ta = 32'h0;
   logic [3:0] waits = 4'h0;
   logic m_ready, m_done, s_valid, boot_external, address_bus_oe, data_bus_oe, strobe_oe;
   logic read_strobe_n_out, write_low_strobe_n_out, write_high_strobe_n_out, ack_out, ack_oe;
   logic boot_memory_select_n, host_space_select_n, select_oe, mem_ack, ack_drv;
   logic read_strobe_n_in, write_low_strobe_n_in, write_high_strobe_n_in, ack_in;
   logic [63:0] m_rdata, s_wdata, data_bus_out, data_bus_in, mem_data, seen_data;
   logic [31:0] address_bus_out, address_bus_in;
   logic [1:0] bank_select_n, seen_wr;
   slave_req_t s_req;
   int bad_count = 0, checks_done = 0;
   // one clock for bus and memory
   always #2.5 mclk = ~mclk;
   // Pin levels from whoever drives; ack pulled up
   assign address_bus_in = address_bus_oe ? address_bus_out : ta;
   assign data_bus_in = data_bus_oe ? data_bus_out : strobe_oe ? mem_data : td;
   assign read_strobe_n_in = strobe_oe ? read_strobe_n_out : trd;
   assign write_low_strobe_n_in = strobe_oe ? write_low_strobe_n_out : twl;
   assign write_high_strobe_n_in = strobe_oe ? write_high_strobe_n_out : twh;
   assign ack_in = ack_oe ? ack_out : mem_ack;
   always_comb ack_drv = ack_oe && ack_out;
   external_bus_control_port u_dut (.*);
   ext_mem_model u_mem (.*);
   ////////////////////////////////////////
   task automatic tick;
      @(posedge mclk);
      #1;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      if (bad_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait; a hang closes the run
   task automatic wait_hi(ref logic s, output int n);
      n = 0;
      while (s !== 1'b1 && n < 60)
      begin
         tick;
         n++;
      end
      if (s !== 1'b1)
      begin
         bad_count++;
         finish_test;
      end
   endtask
   // Master transfer; kind is write, long, zone32
   task automatic xfer(input logic [31:0] a, input logic [2:0] k, input logic [63:0] d, output int n);
      m_req = '{a, d, k[2], k[1], k[0], 1'b0};
      m_valid = 1'b1;
      wait_hi(m_ready, n);
      tick;
      m_valid = 1'b0;
      wait_hi(m_done, n);
   endtask
   task automatic t_reset(input logic strap);
      external_boot_strap = strap;
      rst = 1'b1;
      repeat (4) tick;
      check({address_bus_oe, data_bus_oe, strobe_oe, ack_oe, select_oe}, 5'h00);
      check(boot_external, !strap);
      rst = 1'b0;
      external_boot_strap = 1'b1;
      repeat (2) tick;
   endtask
   task automatic t_reads;
      logic [31:0] a [4] = '{32'h08000010, 32'h0C000021, 32'h10000008, 32'h00000100};
      int n0, n6;
      foreach (a[i])
      begin
         xfer(a[i], 3'h0, 64'h0, n0);
         check(m_rdata, {~a[i], a[i]});
      end
      waits = 4'h6;
      xfer(a[0], 3'h0, 64'h0, n6);
      waits = 4'h0;
      check(64'(n6 - n0), 64'h6);
   endtask
   task automatic t_writes;
      logic [2:0] k [4] = '{3'h4, 3'h4, 3'h6, 3'h5};
      logic [31:0] a [4] = '{32'h08000040, 32'h08000041, 32'h0C000042, 32'h10000043};
      logic [1:0] e [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
      int n;
      foreach (k[i])
      begin
         xfer(a[i], k[i], {a[i], ~a[i]}, n);
         check(seen_wr, e[i]);
         check(seen_data, {a[i], ~a[i]});
      end
   endtask
   task automatic t_slave_rd;
      int n;
      bus_grant = 1'b0;
      ta = 32'h00001234;
      trd = 1'b0;
      wait_hi(ack_oe, n);
      m_valid = 1'b1;
      repeat (3) tick;
      check({ack_in, s_valid, s_req}, {1'b0, 1'b0, ta, 3'h4});
      check({strobe_oe, select_oe, m_ready}, 3'h0);
      s_rdata = 64'h0123456789ABCDEF;
      s_rdata_ready = 1'b1;
      wait_hi(ack_drv, n);
      check(data_bus_in, s_rdata);
      trd = 1'b1;
      s_rdata_ready = 1'b0;
      repeat (4) tick;
   endtask
   task automatic t_slave_wr;
      td = 64'hFEDCBA9876543210;
      twl = 1'b0;
      repeat (3) tick;
      check({s_valid, s_req, ack_oe}, {1'b1, ta, 3'h2, 1'b0});
      check(s_wdata, td);
      twh = 1'b0;
      repeat (3) tick;
      check({s_valid, s_req, ack_oe}, {1'b1, ta, 3'h3, 1'b0});
      twl = 1'b1;
      twh = 1'b1;
      m_valid = 1'b0;
      repeat (4) tick;
      bus_grant = 1'b1;
   endtask
   // Main sequence, with a second reset mid-run
   initial
   begin
      t_reset(1'b0);
      t_reads;
      t_writes;
      t_slave_rd;
      t_slave_wr;
      t_reset(1'b1);
      t_reads;
      finish_test;
   end
endmodule // external_bus_control_port_test
